// *** design/sec_pkg.sv ***
// constants and state types of the serial eeprom command engine
// assumes a 40 MHz system clock and a host-driven serial clock
package sec_pkg;
   localparam int CLK_PERIOD_NS = 25;
   localparam int PROG_TIME_NS = 4000000;
   // a longest time, so the count rounds down
   localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int CTR_W = 18;
   localparam int ADDR_W = 14;
   localparam int PAGE_W = 6;
   localparam int MEM_BYTES = 16384;
   localparam int PAGE_BYTES = 64;
   localparam logic [7:0] OP_ARM = 8'h06;
   localparam logic [7:0] OP_DISARM = 8'h04;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_STAT_RD = 8'h05;
   localparam logic [7:0] OP_STAT_WR = 8'h01;
   // rising edges already seen before the edge of interest
   localparam logic [4:0] CNT_OPC_END = 5'h07;
   localparam logic [4:0] CNT_SW_OPEN = 5'h0e;
   localparam logic [4:0] CNT_SW_LAST = 5'h0f;
   localparam logic [4:0] CNT_ADR_END = 5'h17;
   localparam logic [4:0] CNT_SAT = 5'h18;
   localparam logic [2:0] DCNT_LAST = 3'h7;
   localparam logic [13:0] QUARTER_BASE = 14'h3000;
   localparam logic [13:0] HALF_BASE = 14'h2000;
   localparam int SB_PEN = 7;
   localparam int SB_BP1 = 3;
   localparam int SB_BP0 = 2;
   localparam int SB_WEL = 1;
   localparam int SB_BUSY = 0;
   typedef enum logic [2:0] {
      LM_OPC = 3'b000,
      LM_RD = 3'b001,
      LM_WR = 3'b011,
      LM_SW = 3'b010,
      LM_SR = 3'b110,
      LM_IGN = 3'b111
   } sec_lmode_t;
   typedef enum logic [1:0] {
      MP_IDLE = 2'b00,
      MP_PROG = 2'b01
   } sec_mph_t;
endpackage

// *** design/sec_engine.sv ***
// serial eeprom command engine: link shifter, page buffer, array, programming timer
// accepts a host that clocks sclk_in also while select_low_in is high (mode 3 idle rise)
`timescale 1ns/1ps
`default_nettype none

module sec_engine
   import sec_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic sclk_in,
   input wire logic select_low_in,
   input wire logic sdi_in,
   input wire logic pause_low_in,
   input wire logic protect_pin_low_in,
   output logic sdo_out,
   output logic sdo_oe_n_out
);

   typedef struct packed {
      sec_lmode_t mode;
      logic [4:0] cnt;
      logic [7:0] sh;
      logic [13:0] addr;
      logic [2:0] dcnt;
      logic [7:0] osh;
      logic drv;
      logic wr_ok;
      logic sw_ok;
      logic wp_cut;
      logic [2:0] swv;
      logic fr_tg;
      logic arm_tg;
      logic dis_tg;
      logic [63:0] ld;
      logic [7:0] sr_s1;
      logic [7:0] sr_s2;
   } sec_lk_t;

   typedef struct packed {
      sec_mph_t ph;
      logic [2:0] sel_s;
      logic [2:0] arm_s;
      logic [2:0] dis_s;
      logic [1:0] fr_s;
      logic fr_used;
      logic wel;
      logic pen;
      logic [1:0] bp;
      logic busy;
      logic is_wr;
      logic [17:0] ctr;
   } sec_mc_t;

   function automatic logic sec_prot(input logic [1:0] bp, input logic [13:0] a);
      case (bp)
         2'b00: return 1'b0;
         2'b01: return a >= QUARTER_BASE;
         2'b10: return a >= HALF_BASE;
         default: return 1'b1;
      endcase
   endfunction

   sec_lk_t lk_q, lk_d;
   sec_mc_t st_q, st_d;
   logic seen_q;
   logic so_q;
   logic oe_n_q;
   logic [7:0] mem_q [0:MEM_BYTES-1];
   logic [7:0] pbuf_q [0:PAGE_BYTES-1];
   logic [7:0] status_w;
   logic [7:0] pb_byte;
   logic pb_we;
   logic mem_we;
   logic [13:0] waddr;
   logic busy_l;
   logic pen_l;
   logic [7:0] op_w;
   logic [13:0] a_full;

   ////////////////////////////////////////////////////////////////////
   // link side, serial clock domain

   // set with select high; first edge after it opens a frame
   always_ff @(posedge sclk_in or posedge select_low_in) begin
      if (select_low_in) begin
         seen_q <= 1'b1;
      end else if (pause_low_in) begin
         seen_q <= 1'b0;
      end
   end

   assign busy_l = lk_q.sr_s2[SB_BUSY];
   assign pen_l = lk_q.sr_s2[SB_PEN];
   assign op_w = {lk_q.sh[6:0], sdi_in};
   assign a_full = {lk_q.addr[12:0], sdi_in};
   assign pb_byte = {lk_q.sh[6:0], sdi_in};
   assign pb_we = pause_low_in && !seen_q && lk_q.mode == LM_WR && lk_q.cnt == CNT_SAT
      && lk_q.dcnt == DCNT_LAST;

   always_comb begin
      lk_d = lk_q;
      lk_d.sr_s1 = status_w;
      lk_d.sr_s2 = lk_q.sr_s1;
      // edges while paused or deselected (mode 3 idle rise) leave the frame alone
      if (!pause_low_in || select_low_in) begin
         lk_d.sr_s1 = status_w;
      end else if (seen_q) begin
         lk_d.cnt = 5'h01;
         lk_d.sh = {7'h00, sdi_in};
         lk_d.mode = LM_OPC;
         lk_d.drv = 1'b0;
         lk_d.wr_ok = 1'b0;
         lk_d.sw_ok = 1'b0;
         lk_d.wp_cut = 1'b0;
         lk_d.fr_tg = ~lk_q.fr_tg;
      end else begin
         lk_d.sh = {lk_q.sh[6:0], sdi_in};
         if (lk_q.cnt != CNT_SAT) begin
            lk_d.cnt = lk_q.cnt + 5'h01;
         end
         lk_d.wr_ok = 1'b0;
         lk_d.sw_ok = 1'b0;
         case (lk_q.mode)
            LM_OPC: begin
               if (lk_q.cnt == CNT_OPC_END) begin
                  lk_d.dcnt = 3'h0;
                  lk_d.mode = LM_IGN;
                  if (op_w == OP_STAT_RD) begin
                     lk_d.mode = LM_SR;
                     lk_d.osh = lk_q.sr_s2;
                     lk_d.drv = 1'b1;
                  end else if (!busy_l) begin
                     case (op_w)
                        OP_ARM: lk_d.arm_tg = ~lk_q.arm_tg;
                        OP_DISARM: lk_d.dis_tg = ~lk_q.dis_tg;
                        OP_READ: lk_d.mode = LM_RD;
                        OP_WRITE: begin
                           lk_d.mode = LM_WR;
                           lk_d.ld = '0;
                        end
                        OP_STAT_WR: begin
                           lk_d.mode = LM_SW;
                           lk_d.wp_cut = pen_l && !protect_pin_low_in;
                        end
                        default: lk_d.mode = LM_IGN;
                     endcase
                  end
               end
            end
            LM_RD, LM_WR: begin
               if (lk_q.cnt < CNT_ADR_END) begin
                  lk_d.addr = a_full;
               end else if (lk_q.cnt == CNT_ADR_END) begin
                  lk_d.addr = a_full;
                  lk_d.dcnt = 3'h0;
                  if (lk_q.mode == LM_RD) begin
                     lk_d.osh = mem_q[a_full];
                     lk_d.addr = a_full + 14'h0001;
                     lk_d.drv = 1'b1;
                  end
               end else if (lk_q.dcnt == DCNT_LAST) begin
                  lk_d.dcnt = 3'h0;
                  if (lk_q.mode == LM_RD) begin
                     lk_d.osh = mem_q[lk_q.addr];
                     lk_d.addr = lk_q.addr + 14'h0001;
                  end else begin
                     lk_d.ld[lk_q.addr[5:0]] = 1'b1;
                     lk_d.addr[5:0] = lk_q.addr[5:0] + 6'h01;
                     lk_d.wr_ok = 1'b1;
                  end
               end else begin
                  lk_d.dcnt = lk_q.dcnt + 3'h1;
                  lk_d.osh = {lk_q.osh[6:0], 1'b0};
               end
            end
            LM_SR: begin
               if (lk_q.dcnt == DCNT_LAST) begin
                  lk_d.osh = lk_q.sr_s2;
                  lk_d.dcnt = 3'h0;
               end else begin
                  lk_d.osh = {lk_q.osh[6:0], 1'b0};
                  lk_d.dcnt = lk_q.dcnt + 3'h1;
               end
            end
            LM_SW: begin
               if (pen_l && !protect_pin_low_in) begin
                  lk_d.wp_cut = 1'b1;
               end
               if (lk_q.cnt == CNT_SW_OPEN) begin
                  lk_d.swv = {lk_d.sh[6], lk_d.sh[2], lk_d.sh[1]};
               end
               if (lk_q.cnt == CNT_SW_OPEN || lk_q.cnt == CNT_SW_LAST) begin
                  lk_d.sw_ok = 1'b1;
               end
               if (lk_q.cnt == CNT_SW_LAST) begin
                  lk_d.mode = LM_IGN;
               end
            end
            default: lk_d.mode = LM_IGN;
         endcase
      end
   end

   // link clock may be absent at reset, so this reset acts without it
   always_ff @(posedge sclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         lk_q <= '0;
      end else begin
         lk_q <= lk_d;
      end
   end

   always_ff @(posedge sclk_in) begin
      if (pb_we) begin
         pbuf_q[lk_q.addr[5:0]] <= pb_byte;
      end
   end

   // select high releases at once; stale drive from the last frame held off until first edge
   always_ff @(negedge sclk_in or posedge select_low_in) begin
      if (select_low_in) begin
         so_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else if (pause_low_in) begin
         so_q <= lk_q.osh[7];
         oe_n_q <= ~(lk_q.drv & ~seen_q);
      end
   end

   // pause only masks the held bit, so it is driven again on release
   assign sdo_out = so_q & pause_low_in;
   assign sdo_oe_n_out = oe_n_q | ~pause_low_in;

   ////////////////////////////////////////////////////////////////////
   // system clock domain: write latch, status, programming

   assign status_w = {st_q.pen, 3'b000, st_q.bp, st_q.wel, st_q.busy};
   assign waddr = {lk_q.addr[13:6], st_q.ctr[5:0]};
   // link fields read here are frozen: link edges while select is high leave them alone
   assign mem_we = st_q.ph == MP_PROG && st_q.is_wr && st_q.ctr < CTR_W'(PAGE_BYTES)
      && lk_q.ld[st_q.ctr[5:0]] && !sec_prot(st_q.bp, waddr);

   always_comb begin
      st_d = st_q;
      st_d.sel_s = {st_q.sel_s[1:0], select_low_in};
      st_d.arm_s = {st_q.arm_s[1:0], lk_q.arm_tg};
      st_d.dis_s = {st_q.dis_s[1:0], lk_q.dis_tg};
      st_d.fr_s = {st_q.fr_s[0], lk_q.fr_tg};
      if (st_q.arm_s[2] != st_q.arm_s[1]) begin
         st_d.wel = 1'b1;
      end
      if (st_q.dis_s[2] != st_q.dis_s[1]) begin
         st_d.wel = 1'b0;
      end
      case (st_q.ph)
         MP_IDLE: begin
            // one decision per frame, taken at select release
            if (st_q.sel_s[1] && !st_q.sel_s[2] && st_q.fr_s[1] != st_q.fr_used) begin
               st_d.fr_used = st_q.fr_s[1];
               st_d.ctr = '0;
               if (st_q.wel && lk_q.wr_ok) begin
                  st_d.ph = MP_PROG;
                  st_d.busy = 1'b1;
                  st_d.is_wr = 1'b1;
                  st_d.wel = 1'b0;
               end else if (st_q.wel && lk_q.sw_ok && !lk_q.wp_cut) begin
                  st_d.ph = MP_PROG;
                  st_d.busy = 1'b1;
                  st_d.is_wr = 1'b0;
                  st_d.wel = 1'b0;
                  st_d.pen = lk_q.swv[2];
                  st_d.bp = lk_q.swv[1:0];
               end
            end
         end
         MP_PROG: begin
            // no decision here; frames ended now are only marked spent
            if (st_q.sel_s[1] && !st_q.sel_s[2]) begin
               st_d.fr_used = st_q.fr_s[1];
            end
            if (st_q.ctr == CTR_W'(PROG_CYCLES - 1)) begin
               st_d.ph = MP_IDLE;
               st_d.busy = 1'b0;
            end else begin
               st_d.ctr = st_q.ctr + 18'h00001;
            end
         end
         default: st_d.ph = MP_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // array has no reset: contents are the stored data
   always_ff @(posedge mclk_in) begin
      if (mem_we) begin
         mem_q[waddr] <= pbuf_q[st_q.ctr[5:0]];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks

   sequence s_prog_start;
      $rose(st_q.busy);
   endsequence

   sequence s_sw_start;
      $rose(st_q.busy) && !st_q.is_wr;
   endsequence

   property p_wel_reset;
      @(posedge mclk_in) !resetn_in |=> !st_q.wel && !st_q.busy;
   endproperty
   a_wel_reset: assert property (p_wel_reset) else $error("write latch set after reset");

   property p_need_wel;
      @(posedge mclk_in) disable iff (!resetn_in) s_prog_start |-> $past(st_q.wel);
   endproperty
   a_need_wel: assert property (p_need_wel) else $error("write ran without latch");

   property p_wel_clear;
      @(posedge mclk_in) disable iff (!resetn_in) s_prog_start |-> !st_q.wel;
   endproperty
   a_wel_clear: assert property (p_wel_clear) else $error("latch kept after write");

   property p_prog_end;
      @(posedge mclk_in) disable iff (!resetn_in)
         st_q.busy && st_q.ctr == CTR_W'(PROG_CYCLES - 1) |=> !st_q.busy;
   endproperty
   a_prog_end: assert property (p_prog_end) else $error("busy past program time");

   property p_prog_hold;
      @(posedge mclk_in) disable iff (!resetn_in)
         st_q.busy && st_q.ctr != CTR_W'(PROG_CYCLES - 1) |=> st_q.busy && $changed(st_q.ctr);
   endproperty
   a_prog_hold: assert property (p_prog_hold) else $error("programming cut short");

   property p_protect;
      @(posedge mclk_in) disable iff (!resetn_in)
         mem_we |-> st_q.bp == 2'b00 || (st_q.bp == 2'b01 && waddr < QUARTER_BASE)
         || (st_q.bp == 2'b10 && waddr < HALF_BASE);
   endproperty
   a_protect: assert property (p_protect) else $error("write into protected block");

   property p_sw_bits;
      @(posedge mclk_in) disable iff (!resetn_in)
         s_sw_start |-> {st_q.pen, st_q.bp} == $past(lk_q.swv) && status_w[6:4] == 3'b000;
   endproperty
   a_sw_bits: assert property (p_sw_bits) else $error("status write bits wrong");

   property p_page_wrap;
      @(posedge sclk_in) disable iff (!resetn_in)
         pb_we |=> lk_q.addr[13:6] == $past(lk_q.addr[13:6]) && lk_q.wr_ok;
   endproperty
   a_page_wrap: assert property (p_page_wrap) else $error("page write left its page");

   property p_read_next;
      @(posedge sclk_in) disable iff (!resetn_in)
         pause_low_in && !seen_q && lk_q.mode == LM_RD && lk_q.cnt == CNT_SAT
         && lk_q.dcnt == DCNT_LAST |=> lk_q.addr == $past(lk_q.addr) + 14'h0001;
   endproperty
   a_read_next: assert property (p_read_next) else $error("read address did not advance");

endmodule // sec_engine

`default_nettype wire

// *** test/sec_host_model.sv ***
// host side of the serial link: master that frames, clocks and samples bytes
// assumes the bench fills txb, calls frame and reads rxb afterwards
`timescale 1ns/1ps
`default_nettype none
module sec_host_model (
   output logic sclk_out,
   output logic select_low_out,
   output logic sdi_out,
   output logic pause_low_out,
   output logic protect_pin_low_out,
   input wire logic sdo_in,
   input wire logic sdo_oe_n_in
);
   logic [7:0] txb [0:79];
   logic [7:0] rxb [0:79];
   int pause_at = -1;
   int abort_at = -1;
   logic mode3 = 1'b0;
   logic prot_val = 1'b1;
   logic oe_in_pause;
   assign protect_pin_low_out = prot_val;
   initial begin
      sclk_out = 1'b0;
      select_low_out = 1'b1;
      sdi_out = 1'b0;
      pause_low_out = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   // one frame of nbits; link clock 64 ns, low outside frames except one rise before select falls when mode3 is set
   task automatic frame(input int nbits);
      int i;
      oe_in_pause = 1'b1;
      sclk_out = mode3;
      #10 select_low_out = 1'b0;
      #20 sclk_out = 1'b0;
      for (i = 0; i < nbits; i++) begin
         if (i == pause_at) begin
            pause_low_out = 1'b0;
            // junk clocks and data must be ignored while paused
            repeat (3) begin
               #32 sclk_out = 1'b1;
               oe_in_pause &= sdo_oe_n_in;
               #32 sclk_out = 1'b0;
               sdi_out = ~sdi_out;
            end
         end
         if (i == abort_at) break;
         pause_low_out = 1'b1;
         sdi_out = txb[i/8][7-i%8];
         #32 sclk_out = 1'b1;
         rxb[i/8][7-i%8] = (sdo_oe_n_in === 1'b0) ? sdo_in : 1'bx;
         #32 sclk_out = 1'b0;
      end
      #16 select_low_out = 1'b1;
      pause_low_out = 1'b1;
      sdi_out = ~sdi_out;
      #250;
   endtask
endmodule // sec_host_model
`default_nettype wire

// *** test/spi_eeprom_command_engine_tb.sv ***
// bench of the command engine: command sequences through the host model
// assumes a short programming time so busy ends within a few frames
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_command_engine_tb;
   import sec_pkg::*;
   logic mclk_in = 1'b0;
   logic resetn_in = 1'b1;
   wire sclk_w, sel_low_w, sdi_w, pause_low_w, prot_low_w, sdo_w, sdo_oe_n_w;
   int mismatches = 0;
   int num_checks = 0;
   int b, j;
   logic [7:0] shadow [0:16383];
   logic [7:0] s;
   always #12.5 mclk_in = ~mclk_in;
   sec_engine #(.PROG_CYCLES(100)) DUT (.mclk_in(mclk_in), .resetn_in(resetn_in), .sclk_in(sclk_w),
      .select_low_in(sel_low_w), .sdi_in(sdi_w), .pause_low_in(pause_low_w),
      .protect_pin_low_in(prot_low_w), .sdo_out(sdo_w), .sdo_oe_n_out(sdo_oe_n_w));
   sec_host_model host (.sclk_out(sclk_w), .select_low_out(sel_low_w), .sdi_out(sdi_w),
      .pause_low_out(pause_low_w), .protect_pin_low_out(prot_low_w), .sdo_in(sdo_w), .sdo_oe_n_in(sdo_oe_n_w));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp || $isunknown(exp)) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] op, input int nbits);
      host.txb[0] = op;
      host.frame(nbits);
   endtask
   task automatic rdsr(output logic [7:0] v);
      cmd(OP_STAT_RD, 16);
      v = host.rxb[1];
   endtask
   // bounded poll on busy; a stuck busy shows up in later checks
   task automatic idle();
      int k;
      for (k = 0; k < 40; k++) begin
         rdsr(s);
         if (s[SB_BUSY] === 1'b0) break;
      end
   endtask
   task automatic status_write_cmd(input logic [7:0] v, input int nbits);
      host.txb[1] = v;
      cmd(OP_STAT_WR, nbits);
      idle();
   endtask
   // ok says whether the bytes should land in the array
   task automatic wr(input logic [13:0] a, input int n, input logic [7:0] d0, input logic ok);
      int k;
      host.txb[1] = {2'b00, a[13:8]};
      host.txb[2] = a[7:0];
      for (k = 0; k < n; k++) begin
         host.txb[3+k] = d0 + k[7:0];
         if (ok) shadow[{a[13:6], a[5:0] + k[5:0]}] = d0 + k[7:0];
      end
      cmd(OP_WRITE, 24 + 8 * n);
   endtask
   task automatic rd(input logic [13:0] a, input int n);
      int k;
      host.txb[1] = {2'b00, a[13:8]};
      host.txb[2] = a[7:0];
      cmd(OP_READ, 24 + 8 * n);
      for (k = 0; k < n; k++) chk("read data", shadow[a + k[13:0]], host.rxb[3+k]);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #2000000;
      mismatches++;
      test_done();
   end
   initial begin
      // a real falling edge, so the link-side asynchronous clear fires
      #1 resetn_in = 1'b0;
      repeat (2) @(negedge mclk_in);
      resetn_in = 1'b1;
      @(negedge mclk_in);
      rdsr(s); chk("status after reset", 8'h00, s);
      cmd(OP_ARM, 12); rdsr(s); chk("latch after arm", 8'h02, s);
      cmd(OP_DISARM, 10); rdsr(s); chk("latch after disarm", 8'h00, s);
      cmd(OP_ARM, 8); wr(14'h0040, 64, 8'h10, 1'b1);
      rdsr(s); chk("busy while programming", 8'h01, s);
      cmd(OP_ARM, 8); idle(); rdsr(s); chk("arm ignored while busy", 8'h00, s);
      rd(14'h0040, 64);
      wr(14'h0050, 1, 8'hee, 1'b0); idle(); rd(14'h0050, 1);
      cmd(OP_ARM, 8); wr(14'h007e, 3, 8'ha0, 1'b1); idle(); rd(14'h0040, 64);
      cmd(OP_ARM, 8); wr(14'h0000, 1, 8'h5c, 1'b1); idle();
      cmd(OP_ARM, 8); wr(14'h3fff, 1, 8'hc5, 1'b1); idle(); rd(14'h3fff, 2);
      cmd(OP_ARM, 8); host.abort_at = 35; wr(14'h0040, 2, 8'h77, 1'b0); host.abort_at = -1;
      idle(); rd(14'h0040, 2);
      cmd(OP_ARM, 8); status_write_cmd(8'hff, 16); rdsr(s); chk("status write bits", 8'h8c, s);
      for (b = 0; b < 4; b++) begin
         cmd(OP_ARM, 8); status_write_cmd({4'h0, b[1:0], 2'b00}, 16);
         for (j = 1; j < 4; j++) begin
            cmd(OP_ARM, 8); wr({j[1:0], 12'h000}, 1, {b[3:0], j[3:0]}, b + j < 4); idle();
            rd({j[1:0], 12'h000}, 1);
         end
      end
      cmd(OP_ARM, 8); status_write_cmd(8'h80, 16);
      host.prot_val = 1'b0;
      cmd(OP_ARM, 8); status_write_cmd(8'h0c, 16); rdsr(s); chk("pin blocks status write", 8'h80, s & 8'hfd);
      cmd(OP_ARM, 8); wr(14'h0100, 1, 8'h3c, 1'b1); idle(); rd(14'h0100, 1);
      host.prot_val = 1'b1;
      cmd(OP_ARM, 8); status_write_cmd(8'h00, 16); rdsr(s); chk("status cleared", 8'h00, s);
      host.prot_val = 1'b0;
      cmd(OP_ARM, 8); status_write_cmd(8'h04, 16); rdsr(s); chk("pin inert when disabled", 8'h04, s);
      host.prot_val = 1'b1;
      cmd(OP_ARM, 8); status_write_cmd(8'h08, 15); rdsr(s); chk("commit after edge 15", 8'h08, s);
      cmd(OP_ARM, 8); status_write_cmd(8'h00, 14); rdsr(s); chk("cancel before edge 15", 8'h08, s & 8'hfd);
      cmd(OP_ARM, 8); status_write_cmd(8'h00, 17); rdsr(s); chk("cancel after edge 16", 8'h08, s & 8'hfd);
      cmd(OP_DISARM, 8); rd(14'h3fff, 2);
      host.abort_at = 12; cmd(OP_READ, 40);
      host.abort_at = 5; cmd(OP_STAT_RD, 16); host.abort_at = -1;
      rdsr(s); chk("status after aborted reads", 8'h08, s);
      host.pause_at = 28; rd(14'h0040, 2);
      chk("output released in pause", 8'h01, {7'h00, host.oe_in_pause});
      host.abort_at = 28; cmd(OP_READ, 40); host.pause_at = -1; host.abort_at = -1;
      rd(14'h007e, 2);
      host.mode3 = 1'b1; rdsr(s); host.mode3 = 1'b0;
      chk("first bit after select fall", 8'h08, s);
      test_done();
   end
endmodule // spi_eeprom_command_engine_tb
`default_nettype wire
